// ---- src/twbmc_core.sv ----
`timescale 1ns/100ps
module twbmc_core (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Two-wire bus pins, open drain
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Interrupt
  output logic irq
);

  // True for every register offset that the block decodes.
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == twbmc_pkg::CTRL_OFF) || (a == twbmc_pkg::STAT_OFF) ||
              (a == twbmc_pkg::BYTE_OFF) || (a == twbmc_pkg::OWN_ADDR_OFF) ||
              (a == twbmc_pkg::RATE_OFF) || (a == twbmc_pkg::IRQ_STAT_OFF) ||
              (a == twbmc_pkg::IRQ_MASK_OFF);
  endfunction

  // Cycles in a quarter of a bit time.
  function automatic logic [15:0] quarter_len(input logic [7:0] r, input logic [1:0] p);
    quarter_len = ({8'h00, r} + 16'h0001) << {p, 1'b0};
  endfunction

  logic wr_acc, rd_setup, wr_ctrl, wr_byte, sw_clr_step, wcol_evt;
  logic ack_en_r, sta_r, sto_r, en_r, wcol_r;
  logic [1:0] pre_r;
  logic [7:0] rate_r, own_r, byte_r, shift_r, code_r, stat_view;
  logic [twbmc_pkg::IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_evt;
  logic [31:0] prdata_r;
  twbmc_pkg::twbmc_state_t state_r;
  logic [1:0] phase_r;
  logic [3:0] bitcnt_r;
  logic step_r, step_evt_r, lost_evt_r, sto_done_r;
  logic scl_low_r, sda_low_r;
  logic mtx_r, stx_r, rw_r, addr_r, addr_next_r, rep_r, ack_r, slv_act_r, last_r, busy_r;
  logic scl_m_r, scl_s_r, scl_p_r, sda_m_r, sda_s_r, sda_p_r;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic [15:0] div_r, div_lim;
  logic qtick, mtick;

  // APB strobes; each access phase lasts one cycle.
  assign wr_acc = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign wr_ctrl = wr_acc & (paddr == twbmc_pkg::CTRL_OFF);
  assign wr_byte = wr_acc & (paddr == twbmc_pkg::BYTE_OFF);
  assign sw_clr_step = wr_ctrl & pwdata[twbmc_pkg::CTRL_STEP_BIT];
  assign wcol_evt = wr_byte & ~step_r;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~reg_hit(paddr);
  assign prdata = prdata_r;

  // The code is only meaningful while the step flag is up.
  assign stat_view = step_r ? code_r : twbmc_pkg::NO_INFO_CODE;

  // Open-drain pins only ever pull low.
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = scl_low_r;
  assign sda_oe = sda_low_r;

  // Read data is captured in the setup phase so it stands through the access.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (rd_setup) begin
      unique case (paddr)
        twbmc_pkg::CTRL_OFF: prdata_r <= {24'h000000, step_r, ack_en_r, sta_r, sto_r,
                                          wcol_r, en_r, 2'h0};
        // Only the five code bits travel; bit 2 reads zero and the low two carry the prescaler field.
        twbmc_pkg::STAT_OFF: prdata_r <= {24'h000000, stat_view[7:3], 1'b0, pre_r};
        twbmc_pkg::BYTE_OFF: prdata_r <= {24'h000000, byte_r};
        twbmc_pkg::OWN_ADDR_OFF: prdata_r <= {24'h000000, own_r};
        twbmc_pkg::RATE_OFF: prdata_r <= {24'h000000, rate_r};
        twbmc_pkg::IRQ_STAT_OFF: prdata_r <= {29'h00000000, irq_stat_r};
        twbmc_pkg::IRQ_MASK_OFF: prdata_r <= {29'h00000000, irq_mask_r};
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // Control bits owned by software; the stop request clears itself.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_en_r <= 1'b0;
      sta_r <= 1'b0;
      sto_r <= 1'b0;
      en_r <= 1'b0;
      wcol_r <= 1'b0;
    end else begin
      if (sto_done_r) begin
        sto_r <= 1'b0;
      end
      if (wr_ctrl) begin
        ack_en_r <= pwdata[twbmc_pkg::CTRL_ACK_BIT];
        sta_r <= pwdata[twbmc_pkg::CTRL_STA_BIT];
        sto_r <= pwdata[twbmc_pkg::CTRL_STO_BIT];
        en_r <= pwdata[twbmc_pkg::CTRL_EN_BIT];
      end
      // A byte write outside a step is dropped and flagged.
      if (wr_byte) begin
        wcol_r <= ~step_r;
      end
    end
  end

  // Prescaler, rate and own slave address.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre_r <= twbmc_pkg::PRE_RST;
      rate_r <= twbmc_pkg::RATE_RST;
      own_r <= twbmc_pkg::OWN_ADDR_RST;
    end else if (wr_acc) begin
      if (paddr == twbmc_pkg::STAT_OFF) begin
        pre_r <= pwdata[1:0];
      end
      if (paddr == twbmc_pkg::RATE_OFF) begin
        rate_r <= pwdata[7:0];
      end
      if (paddr == twbmc_pkg::OWN_ADDR_OFF) begin
        own_r <= pwdata[7:0];
      end
    end
  end

  // Sticky interrupt status, write one to clear; a new event wins the clear.
  assign irq_evt = {lost_evt_r, wcol_evt, step_evt_r};
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_stat_r <= twbmc_pkg::IRQ_RST;
      irq_mask_r <= twbmc_pkg::IRQ_RST;
    end else begin
      if (wr_acc && paddr == twbmc_pkg::IRQ_STAT_OFF) begin
        irq_stat_r <= (irq_stat_r & ~pwdata[twbmc_pkg::IRQ_W-1:0]) | irq_evt;
      end else begin
        irq_stat_r <= irq_stat_r | irq_evt;
      end
      if (wr_acc && paddr == twbmc_pkg::IRQ_MASK_OFF) begin
        irq_mask_r <= pwdata[twbmc_pkg::IRQ_W-1:0];
      end
    end
  end

  // Level interrupt while any unmasked status bit is set.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // Two-stage synchronisers, plus a third stage for edge detection.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_p_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_p_r <= 1'b1;
    end else begin
      scl_m_r <= scl_i;
      scl_s_r <= scl_m_r;
      scl_p_r <= scl_s_r;
      sda_m_r <= sda_i;
      sda_s_r <= sda_m_r;
      sda_p_r <= sda_s_r;
    end
  end

  // Bus line events seen by the slave role and the busy flag.
  assign scl_rise = scl_s_r & ~scl_p_r;
  assign scl_fall = ~scl_s_r & scl_p_r;
  assign start_det = scl_s_r & scl_p_r & ~sda_s_r & sda_p_r;
  assign stop_det = scl_s_r & scl_p_r & sda_s_r & ~sda_p_r;

  // Bus busy from any start until the next stop or until the block is disabled.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy_r <= 1'b0;
    end else if (start_det) begin
      busy_r <= 1'b1;
    end else if (stop_det || !en_r) begin
      busy_r <= 1'b0;
    end
  end

  // Quarter-bit divider; phase 2 also waits for a stretched clock to rise.
  assign div_lim = quarter_len(rate_r, pre_r);
  assign qtick = (div_r >= div_lim - 16'h0001);
  assign mtick = qtick & ((phase_r != 2'd2) | scl_s_r);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_r <= 16'h0000;
    end else if (qtick || state_r == twbmc_pkg::TWBMC_IDLE) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end

  // Byte engine for all four roles, with the step flag handshake.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= twbmc_pkg::TWBMC_IDLE;
      phase_r <= 2'd0;
      bitcnt_r <= 4'h0;
      shift_r <= 8'h00;
      byte_r <= twbmc_pkg::BYTE_RST;
      code_r <= twbmc_pkg::NO_INFO_CODE;
      step_r <= 1'b0;
      step_evt_r <= 1'b0;
      lost_evt_r <= 1'b0;
      sto_done_r <= 1'b0;
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
      mtx_r <= 1'b0;
      stx_r <= 1'b0;
      rw_r <= 1'b0;
      addr_r <= 1'b0;
      addr_next_r <= 1'b0;
      rep_r <= 1'b0;
      ack_r <= 1'b0;
      slv_act_r <= 1'b0;
      last_r <= 1'b0;
    end else if (!en_r) begin
      state_r <= twbmc_pkg::TWBMC_IDLE;
      step_r <= 1'b0;
      step_evt_r <= 1'b0;
      lost_evt_r <= 1'b0;
      sto_done_r <= 1'b0;
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
      slv_act_r <= 1'b0;
    end else begin
      step_evt_r <= 1'b0;
      lost_evt_r <= 1'b0;
      sto_done_r <= 1'b0;
      if (sw_clr_step) begin
        step_r <= 1'b0;
      end
      if (wr_byte && step_r) begin
        byte_r <= pwdata[7:0];
      end
      unique case (state_r)
        twbmc_pkg::TWBMC_IDLE: begin
          phase_r <= 2'd0;
          // Master request first, then an address from another master.
          if (sta_r && !busy_r && !step_r) begin
            state_r <= twbmc_pkg::TWBMC_START;
            rep_r <= 1'b0;
          end else if (start_det && !step_r) begin
            state_r <= twbmc_pkg::TWBMC_SBIT;
            addr_r <= 1'b1;
            stx_r <= 1'b0;
            // The clock fall that closes the start wraps the count to zero.
            bitcnt_r <= 4'hf;
            slv_act_r <= 1'b0;
          end
        end
        twbmc_pkg::TWBMC_START: begin
          if (mtick) begin
            phase_r <= phase_r + 2'd1;
            unique case (phase_r)
              2'd0: sda_low_r <= 1'b0;
              2'd1: scl_low_r <= 1'b0;
              2'd2: sda_low_r <= 1'b1;
              default: begin
                scl_low_r <= 1'b1;
                step_r <= 1'b1;
                step_evt_r <= 1'b1;
                code_r <= rep_r ? twbmc_pkg::RESTART_SENT_CODE : twbmc_pkg::START_SENT_CODE;
                addr_next_r <= 1'b1;
                state_r <= twbmc_pkg::TWBMC_MWAIT;
              end
            endcase
          end
        end
        twbmc_pkg::TWBMC_MWAIT: begin
          // Clock is held low until software clears the step flag.
          phase_r <= 2'd0;
          if (!step_r) begin
            if (sto_r) begin
              state_r <= twbmc_pkg::TWBMC_STOP;
            end else if (sta_r) begin
              state_r <= twbmc_pkg::TWBMC_START;
              rep_r <= 1'b1;
            end else begin
              state_r <= twbmc_pkg::TWBMC_MBIT;
              shift_r <= byte_r;
              bitcnt_r <= 4'h0;
              addr_r <= addr_next_r;
              addr_next_r <= 1'b0;
              if (addr_next_r) begin
                mtx_r <= 1'b1;
                rw_r <= byte_r[0];
              end
            end
          end
        end
        twbmc_pkg::TWBMC_MBIT: begin
          if (mtick) begin
            phase_r <= phase_r + 2'd1;
            unique case (phase_r)
              2'd0: begin
                if (bitcnt_r < twbmc_pkg::ACK_SLOT) begin
                  sda_low_r <= mtx_r & ~shift_r[7];
                end else begin
                  sda_low_r <= ~mtx_r & ack_en_r;
                end
              end
              2'd1: scl_low_r <= 1'b0;
              2'd2: begin
                if (bitcnt_r < twbmc_pkg::ACK_SLOT) begin
                  if (mtx_r && shift_r[7] && !sda_s_r) begin
                    // Another master drove low over our released one.
                    state_r <= twbmc_pkg::TWBMC_IDLE;
                    scl_low_r <= 1'b0;
                    sda_low_r <= 1'b0;
                    step_r <= 1'b1;
                    step_evt_r <= 1'b1;
                    lost_evt_r <= 1'b1;
                    code_r <= twbmc_pkg::ARB_LOST_CODE;
                  end else begin
                    shift_r <= {shift_r[6:0], sda_s_r};
                  end
                end else begin
                  ack_r <= ~sda_s_r;
                end
              end
              default: begin
                scl_low_r <= 1'b1;
                if (bitcnt_r == twbmc_pkg::ACK_SLOT) begin
                  // Flag only after the acknowledge slot has been sampled.
                  step_r <= 1'b1;
                  step_evt_r <= 1'b1;
                  state_r <= twbmc_pkg::TWBMC_MWAIT;
                  if (addr_r && rw_r) begin
                    code_r <= ack_r ? twbmc_pkg::ADDR_R_ACKED_CODE :
                                      twbmc_pkg::ADDR_R_NACKED_CODE;
                    mtx_r <= ~ack_r;
                  end else if (addr_r) begin
                    code_r <= ack_r ? twbmc_pkg::ADDR_W_ACKED_CODE :
                                      twbmc_pkg::ADDR_W_NACKED_CODE;
                  end else if (mtx_r) begin
                    code_r <= ack_r ? twbmc_pkg::DATA_ACKED_CODE :
                                      twbmc_pkg::DATA_NACKED_CODE;
                  end else begin
                    code_r <= ack_r ? twbmc_pkg::MRX_ACKED_CODE : twbmc_pkg::MRX_NACKED_CODE;
                    byte_r <= shift_r;
                  end
                end else begin
                  bitcnt_r <= bitcnt_r + 4'h1;
                end
              end
            endcase
          end
        end
        twbmc_pkg::TWBMC_STOP: begin
          if (mtick) begin
            phase_r <= phase_r + 2'd1;
            unique case (phase_r)
              2'd0: sda_low_r <= 1'b1;
              2'd1: scl_low_r <= 1'b0;
              2'd2: sda_low_r <= 1'b1;
              default: begin
                sda_low_r <= 1'b0;
                sto_done_r <= 1'b1;
                state_r <= twbmc_pkg::TWBMC_IDLE;
              end
            endcase
          end
        end
        twbmc_pkg::TWBMC_SBIT: begin
          scl_low_r <= 1'b0;
          if (start_det || stop_det) begin
            sda_low_r <= 1'b0;
            if (slv_act_r) begin
              step_r <= 1'b1;
              step_evt_r <= 1'b1;
              code_r <= twbmc_pkg::SLV_END_CODE;
            end
            slv_act_r <= 1'b0;
            addr_r <= 1'b1;
            stx_r <= 1'b0;
            bitcnt_r <= 4'hf;
            state_r <= (start_det && !slv_act_r) ? twbmc_pkg::TWBMC_SBIT :
                                                   twbmc_pkg::TWBMC_IDLE;
          end else if (scl_rise) begin
            if (bitcnt_r < twbmc_pkg::ACK_SLOT && !stx_r) begin
              shift_r <= {shift_r[6:0], sda_s_r};
            end else if (bitcnt_r == twbmc_pkg::ACK_SLOT) begin
              ack_r <= ~sda_s_r;
            end
          end else if (scl_fall) begin
            if (bitcnt_r == 4'h7 && !stx_r) begin
              bitcnt_r <= twbmc_pkg::ACK_SLOT;
              if (addr_r) begin
                if (shift_r[7:1] == own_r[7:1] && ack_en_r) begin
                  sda_low_r <= 1'b1;
                  rw_r <= shift_r[0];
                end else begin
                  state_r <= twbmc_pkg::TWBMC_IDLE;
                end
              end else begin
                sda_low_r <= ack_en_r;
                byte_r <= shift_r;
              end
            end else if (bitcnt_r == twbmc_pkg::ACK_SLOT) begin
              // Slot over: stretch the clock and hand the step to software.
              sda_low_r <= 1'b0;
              scl_low_r <= 1'b1;
              step_r <= 1'b1;
              step_evt_r <= 1'b1;
              slv_act_r <= 1'b1;
              state_r <= twbmc_pkg::TWBMC_SWAIT;
              if (addr_r) begin
                code_r <= rw_r ? twbmc_pkg::OWN_R_CODE : twbmc_pkg::OWN_W_CODE;
                stx_r <= rw_r;
                last_r <= 1'b0;
              end else if (stx_r) begin
                code_r <= ack_r ? twbmc_pkg::STX_ACKED_CODE : twbmc_pkg::STX_NACKED_CODE;
                last_r <= ~ack_r;
              end else begin
                code_r <= sda_low_r ? twbmc_pkg::SRX_ACKED_CODE : twbmc_pkg::SRX_NACKED_CODE;
                last_r <= ~sda_low_r;
              end
            end else begin
              bitcnt_r <= bitcnt_r + 4'h1;
              if (stx_r) begin
                sda_low_r <= (bitcnt_r == 4'h7) ? 1'b0 : ~shift_r[6];
                shift_r <= {shift_r[6:0], 1'b0};
              end
            end
          end
        end
        default: begin
          // Waiting slave: drive the first bit when transmitting, release the clock a cycle later; after the last byte release it at once.
          if (!step_r) begin
            addr_r <= 1'b0;
            bitcnt_r <= 4'h0;
            if (last_r) begin
              scl_low_r <= 1'b0;
              slv_act_r <= 1'b0;
              state_r <= twbmc_pkg::TWBMC_IDLE;
            end else begin
              state_r <= twbmc_pkg::TWBMC_SBIT;
              if (stx_r) begin
                shift_r <= byte_r;
                sda_low_r <= ~byte_r[7];
              end
            end
          end
        end
      endcase
    end
  end

endmodule

// ---- src/twbmc_pkg.sv ----
package twbmc_pkg;

  // Register byte offsets on the APB port.
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;
  localparam logic [7:0] BYTE_OFF = 8'h08;
  localparam logic [7:0] OWN_ADDR_OFF = 8'h0c;
  localparam logic [7:0] RATE_OFF = 8'h10;
  localparam logic [7:0] IRQ_STAT_OFF = 8'h14;
  localparam logic [7:0] IRQ_MASK_OFF = 8'h18;

  // Field positions in the bus control register.
  localparam int CTRL_STEP_BIT = 7;
  localparam int CTRL_ACK_BIT = 6;
  localparam int CTRL_STA_BIT = 5;
  localparam int CTRL_STO_BIT = 4;
  localparam int CTRL_WCOL_BIT = 3;
  localparam int CTRL_EN_BIT = 2;

  // Interrupt status and mask layout.
  localparam int IRQ_W = 3;
  localparam int IRQ_STEP_BIT = 0;
  localparam int IRQ_WCOL_BIT = 1;
  localparam int IRQ_LOST_BIT = 2;

  // Values after reset.
  localparam logic [7:0] RATE_RST = 8'h18;
  localparam logic [7:0] OWN_ADDR_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'hff;
  localparam logic [1:0] PRE_RST = 2'h0;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  // Status codes; the low three bits are always zero.
  localparam logic [7:0] CODE_MASK = 8'hf8;
  localparam logic [7:0] NO_INFO_CODE = 8'hf8;
  localparam logic [7:0] START_SENT_CODE = 8'h08;
  localparam logic [7:0] RESTART_SENT_CODE = 8'h10;
  localparam logic [7:0] ADDR_W_ACKED_CODE = 8'h18;
  localparam logic [7:0] ADDR_W_NACKED_CODE = 8'h20;
  localparam logic [7:0] DATA_ACKED_CODE = 8'h28;
  localparam logic [7:0] DATA_NACKED_CODE = 8'h30;
  localparam logic [7:0] ARB_LOST_CODE = 8'h38;
  localparam logic [7:0] ADDR_R_ACKED_CODE = 8'h40;
  localparam logic [7:0] ADDR_R_NACKED_CODE = 8'h48;
  localparam logic [7:0] MRX_ACKED_CODE = 8'h50;
  localparam logic [7:0] MRX_NACKED_CODE = 8'h58;
  localparam logic [7:0] OWN_W_CODE = 8'h60;
  localparam logic [7:0] SRX_ACKED_CODE = 8'h80;
  localparam logic [7:0] SRX_NACKED_CODE = 8'h88;
  localparam logic [7:0] SLV_END_CODE = 8'ha0;
  localparam logic [7:0] OWN_R_CODE = 8'ha8;
  localparam logic [7:0] STX_ACKED_CODE = 8'hb8;
  localparam logic [7:0] STX_NACKED_CODE = 8'hc0;

  // Bit counter value of the acknowledge slot.
  localparam logic [3:0] ACK_SLOT = 4'h8;

  // Engine states.
  typedef enum logic [6:0] {
    TWBMC_IDLE = 7'b0000001,
    TWBMC_START = 7'b0000010,
    TWBMC_MBIT = 7'b0000100,
    TWBMC_MWAIT = 7'b0001000,
    TWBMC_STOP = 7'b0010000,
    TWBMC_SBIT = 7'b0100000,
    TWBMC_SWAIT = 7'b1000000
  } twbmc_state_t;

endpackage

// ---- test/twbmc_core_asserts.sv ----
`timescale 1ns/100ps
module twbmc_core_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // APB slave side
  input wire logic psel, penable, pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic pready, pslverr,
  // Bus pins and interrupt
  input wire logic scl_i, scl_o, scl_oe, sda_i, sda_o, sda_oe, irq
);
  // All checks run on the system clock and sleep during reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_pins_drive_low: assert property (scl_o == 1'h0 && sda_o == 1'h0)
    else $error("open drain pin drives high");
  a_always_ready: assert property (pready)
    else $error("pready low");
  a_unmapped_err: assert property (psel && penable && paddr > 8'h18 |-> pslverr)
    else $error("unmapped access without error");
  a_mapped_ok: assert property (psel && penable && paddr <= 8'h18 && paddr[1:0] == 2'h0
    |-> !pslverr) else $error("mapped access flagged as error");
  a_status_masked: assert property (psel && penable && !pwrite && paddr == 8'h04
    |-> prdata[31:8] == 24'h0 && prdata[2] == 1'h0) else $error("status read bad bits");
  a_ctrl_low_bits: assert property (psel && penable && !pwrite && paddr == 8'h00
    |-> prdata[1:0] == 2'h0) else $error("control low bits set");
  a_mask_quiet: assert property (psel && penable && pwrite && paddr == 8'h18
    && pwdata[2:0] == 3'h0 |-> ##2 !irq) else $error("irq high while masked");
  a_disable_release: assert property (psel && penable && pwrite && paddr == 8'h00
    && !pwdata[2] |-> ##[1:4] (!scl_oe && !sda_oe)) else $error("lines held when off");
endmodule

bind twbmc_core twbmc_core_asserts twbmc_core_asserts_i (.clk(clk), .resetn(resetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl_i), .scl_o(scl_o),
  .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));

// ---- test/twbmc_slave_model.sv ----
`timescale 1ns/100ps
module twbmc_slave_model (
  // Clock and wire levels
  input wire logic clk,
  input wire logic scl,
  input wire logic sda,
  // Control and observation
  input wire logic nack,
  output logic sda_oe,
  output logic [7:0] last_byte,
  output logic stop_seen
);
  logic scl_q = 1'h1;
  logic sda_q = 1'h1;
  logic act = 1'h0;
  logic [3:0] cnt = 4'h0;
  logic [7:0] sh = 8'h0;

  // Receiving slave: frames bytes between start and stop, answers each.
  initial begin
    sda_oe = 1'h0;
    last_byte = 8'h0;
    stop_seen = 1'h0;
  end
  always @(posedge clk) begin
    scl_q <= scl;
    sda_q <= sda;
    if (scl && scl_q && sda_q && !sda) begin
      act <= 1'h1;
      cnt <= 4'hf;
      stop_seen <= 1'h0;
    end else if (scl && scl_q && !sda_q && sda) begin
      act <= 1'h0;
      sda_oe <= 1'h0;
      stop_seen <= 1'h1;
    end else if (act && scl && !scl_q && cnt < 4'h8) begin
      sh <= {sh[6:0], sda};
    end else if (act && !scl && scl_q) begin
      if (cnt == 4'h7) begin
        sda_oe <= !nack;
        last_byte <= sh;
        cnt <= 4'h8;
      end else if (cnt == 4'h8) begin
        sda_oe <= 1'h0;
        cnt <= 4'h0;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule

// ---- test/two_wire_bus_mode_core_test.sv ----
`timescale 1ns/100ps
module two_wire_bus_mode_core_test;
  logic clk = 1'h0;
  logic resetn, psel, penable, pwrite, rerr, nack;
  logic [7:0] paddr, last_byte;
  logic [31:0] pwdata, prdata, rdat;
  logic pready, pslverr, scl_oe, sda_oe, m_oe, scl_o, sda_o, irq, stop_seen;
  logic b_scl, b_sda;
  localparam logic [7:0] SLV_ADDR = 8'h52;
  wire scl_w = !(scl_oe || b_scl);
  wire sda_w = !(sda_oe || m_oe || b_sda);
  int failures = 0;
  int num_checks = 0;
  logic [7:0] offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
  logic [31:0] rstv [7] = '{32'h0, 32'hf8, 32'hff, 32'h0, 32'h18, 32'h0, 32'h0};
  // Rows: byte written, control written, slave refuses, expected code.
  logic [31:0] rows [6] = '{32'h00_24_00_08, 32'h52_84_00_18, 32'ha5_84_00_28,
    32'h3c_84_01_30, 32'h00_24_00_08, 32'h53_84_01_48};

  twbmc_core twbmc_core_i (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
  twbmc_slave_model twbmc_slave_model_i (.clk(clk), .scl(scl_w), .sda(sda_w),
    .nack(nack), .sda_oe(m_oe), .last_byte(last_byte), .stop_seen(stop_seen));

  // Free running system clock.
  always #12.5 clk = ~clk;

  task automatic end_of_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; read data and error are taken at the ready edge.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // One bit sent by the bench acting as a bus master; clock left low.
  task automatic bbit(input logic v);
    b_sda <= !v;
    repeat (20) @(posedge clk);
    b_scl <= 1'h0;
    repeat (20) @(posedge clk);
    b_scl <= 1'h1;
    repeat (20) @(posedge clk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'h0, a, 32'h0);
    chk(rdat, exp);
  endtask

  // A hang is cut short well beyond the expected run length.
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    $display("[FAIL] %0t timeout", $time);
    end_of_test();
  end

  // Reset, register defaults, then the master transfer table.
  initial begin
    {psel, penable, pwrite, nack} = 4'h0;
    {b_scl, b_sda} = 2'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    resetn = 1'h0;
    repeat (12) @(posedge clk);
    resetn <= 1'h1;
    for (int i = 0; i < 7; i++) rdc(offs[i], rstv[i]);
    xfer(1'h0, 8'h1c, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    chk(rdat, 32'h0);
    xfer(1'h1, 8'h10, 32'h3);
    xfer(1'h1, 8'h18, 32'h1);
    for (int i = 0; i < 6; i++) begin
      nack <= rows[i][8];
      if (rows[i][23:16] != 8'h24) xfer(1'h1, 8'h08, {24'h0, rows[i][31:24]});
      xfer(1'h1, 8'h00, {24'h0, rows[i][23:16]});
      for (int k = 0; k < 2000 && irq !== 1'h1; k++) @(posedge clk);
      chk(irq, 1'h1);
      rdc(8'h04, {24'h0, rows[i][7:0]});
      if (rows[i][23:16] != 8'h24) chk(last_byte, rows[i][31:24]);
      repeat (40) @(posedge clk);
      chk(scl_oe, 1'h1);
      if (i == 0) begin
        xfer(1'h1, 8'h18, 32'h0);
        repeat (3) @(posedge clk);
        chk(irq, 1'h0);
        rdc(8'h14, 32'h1);
        xfer(1'h1, 8'h18, 32'h1);
      end
      if (i == 1) begin
        xfer(1'h1, 8'h00, 32'h4);
        rdc(8'h00, 32'h84);
      end
      xfer(1'h1, 8'h14, 32'h1);
      repeat (3) @(posedge clk);
      chk(irq, 1'h0);
      if (rows[i][8]) begin
        xfer(1'h1, 8'h00, 32'h94);
        for (int k = 0; k < 100; k++) begin
          xfer(1'h0, 8'h00, 32'h0);
          if (rdat[4] === 1'h0) break;
        end
        chk(rdat, 32'h4);
        chk({stop_seen, scl_w, sda_w}, 3'h7);
      end
    end
    xfer(1'h1, 8'h00, 32'h0);
    rdc(8'h00, 32'h0);
    // A byte written while the flag is low is dropped and flagged.
    xfer(1'h1, 8'h08, 32'h77);
    rdc(8'h00, 32'h8);
    rdc(8'h14, 32'h2);
    rdc(8'h08, 32'h53);
    // The bench addresses the block as a slave; the model stays silent.
    xfer(1'h1, 8'h0c, {24'h0, SLV_ADDR});
    xfer(1'h1, 8'h00, 32'h44);
    nack <= 1'h1;
    b_sda <= 1'h1;
    repeat (20) @(posedge clk);
    b_scl <= 1'h1;
    for (int b = 7; b >= 0; b--) bbit(SLV_ADDR[b]);
    b_sda <= 1'h0;
    repeat (20) @(posedge clk);
    b_scl <= 1'h0;
    repeat (10) @(posedge clk);
    chk({31'h0, sda_w}, 32'h0);
    repeat (10) @(posedge clk);
    b_scl <= 1'h1;
    repeat (40) @(posedge clk);
    rdc(8'h04, 32'h60);
    chk({31'h0, scl_oe}, 32'h1);
    xfer(1'h1, 8'h00, 32'hc4);
    repeat (10) @(posedge clk);
    chk({30'h0, scl_oe, sda_oe}, 32'h0);
    xfer(1'h1, 8'h00, 32'h0);
    end_of_test();
  end
endmodule
